// [logic/clk_mode_ctrl.sv]
`timescale 1ns/1ps
module clk_mode_ctrl #(
  parameter int lock_serial_bit_clock_cyc = clk_mode_pkg::lock_serial_bit_clock_cycles,
  parameter int lock_master_clock_input_cyc = clk_mode_pkg::lock_master_clock_input_cycles,
  parameter int frame_div = clk_mode_pkg::frame_div_default
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic powerdown_pin_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic frame_clock_i,
  output logic frame_clock_o,
  output logic frame_clock_oe,
  input wire logic serial_bit_clock_i,
  output logic serial_bit_clock_o,
  output logic serial_bit_clock_oe,
  output logic master_clock_output,
  output logic dmic_clock_output,
  output logic adc_output_valid,
  output logic pll_locked
);
  import clk_mode_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset: pin synchronised, combined with bus reset
  logic pd_s1_q, pd_s2_q, rst_n;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pd_s1_q <= 1'b0;
      pd_s2_q <= 1'b0;
    end
    else
    begin
      pd_s1_q <= powerdown_pin_n;
      pd_s2_q <= pd_s1_q;
    end
  end
  assign rst_n = pd_s2_q;

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  logic [31:0] ctrl_q, cfg_q;
  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic adc_start;
  wire take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      if (take)
        wr_addr_q <= haddr;
    end
  end

  // power-down clears registers too: slave mode on exit
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= ctrl_reset;
      cfg_q <= cfg_reset;
    end
    else if (!rst_n)
    begin
      ctrl_q <= ctrl_reset;
      cfg_q <= cfg_reset;
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q[7:0] == ctrl_off[7:0])
        ctrl_q <= {24'h00_0000, hwdata[7:0]};
      else if (wr_addr_q[7:0] == cfg_off[7:0])
        cfg_q <= {20'h0_0000, hwdata[11:0]};
    end
  end

  // adc power rising edge starts the valid delay
  assign adc_start = wr_pend_q && wr_addr_q[7:0] == ctrl_off[7:0]
    && ((hwdata[ctrl_left_adc] && !ctrl_q[ctrl_left_adc])
    || (hwdata[ctrl_right_adc] && !ctrl_q[ctrl_right_adc]));

  logic [31:0] status;
  logic ref_ok;
  clk_mode_e mode;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite)
    begin
      if (haddr[7:0] == ctrl_off[7:0])
        hrdata <= ctrl_q;
      else if (haddr[7:0] == cfg_off[7:0])
        hrdata <= cfg_q;
      else if (haddr[7:0] == status_off[7:0])
        hrdata <= status;
      else
        hrdata <= 32'h0000_0000;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // mode decode and pll model
  wire pll_on = ctrl_q[ctrl_pll_power];
  wire master = ctrl_q[ctrl_master_sel];
  wire [3:0] ref_sel = cfg_q[cfg_ref_lsb +: 4];
  wire [3:0] rate_sel = cfg_q[cfg_rate_lsb +: 4];
  wire [1:0] div_sel = cfg_q[cfg_div_lsb +: 2];
  wire [1:0] adc_init = cfg_q[cfg_adc_init_lsb +: 2];
  assign mode = clk_mode_e'({pll_on, master});

  always_comb
  begin
    unique case (ref_sel)
      ref_bit32, ref_bit64, ref_m11, ref_m12, ref_m24, ref_m13, ref_m27: ref_ok = 1'b1;
      default: ref_ok = 1'b0;
    endcase
  end
  wire ref_is_serial_bit_clock = ref_sel == ref_bit32 || ref_sel == ref_bit64;

  // lock counter restarts on power-up or rate change
  logic [31:0] lock_cnt_q;
  logic [3:0] rate_prev_q;
  logic locked_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lock_cnt_q <= 32'h0000_0000;
      locked_q <= 1'b0;
      rate_prev_q <= 4'h0;
    end
    else
    begin
      rate_prev_q <= rate_sel;
      if (!rst_n || !pll_on || !ref_ok || rate_prev_q != rate_sel)
      begin
        lock_cnt_q <= 32'h0000_0000;
        locked_q <= 1'b0;
      end
      else if (!locked_q)
      begin
        lock_cnt_q <= lock_cnt_q + 32'd1;
        if (lock_cnt_q >= 32'(ref_is_serial_bit_clock ? lock_serial_bit_clock_cyc : lock_master_clock_input_cyc) - 32'd1)
          locked_q <= 1'b1;
      end
    end
  end
  assign pll_locked = locked_q;

  ////////////////////////////////////////////////////////////////////////
  // clock generation: 512fs base tick from divider
  // frame_div hclk cycles per frame; simplification of the analog pll
  // a 256fs clock toggles at 512fs, so the phase counter runs at that rate, twice 256fs
  localparam int tick_div = frame_div / 512;
  logic [15:0] tick_cnt_q;
  logic [8:0] ph_q;
  wire tick = tick_cnt_q == 16'(tick_div - 1);
  wire gen_run = master && (pll_on ? locked_q : 1'b1) && ctrl_q[ctrl_vcm_power];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt_q <= 16'h0000;
      ph_q <= 9'h000;
    end
    else if (!rst_n)
    begin
      tick_cnt_q <= 16'h0000;
      ph_q <= 9'h000;
    end
    else
    begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      if (tick)
        ph_q <= ph_q + 9'h001;
    end
  end

  // pin direction follows master select only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      frame_clock_oe <= 1'b0;
      serial_bit_clock_oe <= 1'b0;
    end
    else if (!rst_n)
    begin
      frame_clock_oe <= 1'b0;
      serial_bit_clock_oe <= 1'b0;
    end
    else
    begin
      frame_clock_oe <= master;
      serial_bit_clock_oe <= master;
    end
  end

  // frame and bit clocks: idle levels while the generator is stopped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      frame_clock_o <= 1'b0;
      serial_bit_clock_o <= 1'b1;
    end
    else if (!rst_n)
    begin
      frame_clock_o <= 1'b0;
      serial_bit_clock_o <= 1'b1;
    end
    else if (gen_run)
    begin
      frame_clock_o <= ph_q[8];
      serial_bit_clock_o <= ctrl_q[ctrl_bit_rate] ? ph_q[2] : ph_q[3];
    end
    else
    begin
      frame_clock_o <= 1'b0;
      serial_bit_clock_o <= 1'b1;
    end
  end

  // dmic and master clock outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      master_clock_output <= 1'b0;
      dmic_clock_output <= 1'b0;
    end
    else if (!rst_n)
    begin
      master_clock_output <= 1'b0;
      dmic_clock_output <= 1'b0;
    end
    else
    begin
      dmic_clock_output <= ph_q[2];
      // only pll modes drive this pin once locked; hides the unlocked garbage
      if (ctrl_q[ctrl_mclk_out_en] && pll_on && locked_q)
        master_clock_output <= ph_q[2'(div_sel)];
      else
        master_clock_output <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // adc valid delay on frame clock rising edges
  logic fr_s1_q, fr_s2_q, fr_s3_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fr_s1_q <= 1'b0;
      fr_s2_q <= 1'b0;
      fr_s3_q <= 1'b0;
    end
    else
    begin
      fr_s1_q <= master ? frame_clock_o : frame_clock_i;
      fr_s2_q <= fr_s1_q;
      fr_s3_q <= fr_s2_q;
    end
  end
  wire fr_rise = fr_s2_q && !fr_s3_q;

  logic [11:0] adc_cnt_q;
  logic adc_busy_q;
  logic [11:0] adc_target;
  always_comb
  begin
    unique case (adc_init)
      2'b00: adc_target = adc_wait_00;
      2'b01: adc_target = adc_wait_01;
      default: adc_target = adc_wait_1x;
    endcase
  end
  wire adc_on = ctrl_q[ctrl_left_adc] || ctrl_q[ctrl_right_adc];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      adc_cnt_q <= 12'h000;
      adc_busy_q <= 1'b0;
      adc_output_valid <= 1'b0;
    end
    else if (!rst_n || (!adc_on && !adc_start))
    begin
      adc_cnt_q <= 12'h000;
      adc_busy_q <= 1'b0;
      adc_output_valid <= 1'b0;
    end
    else if (adc_start)
    begin
      adc_cnt_q <= 12'h000;
      adc_busy_q <= 1'b1;
      adc_output_valid <= 1'b0;
    end
    else if (adc_busy_q && fr_rise)
    begin
      adc_cnt_q <= adc_cnt_q + 12'h001;
      if (adc_cnt_q + 12'h001 >= adc_target)
      begin
        adc_busy_q <= 1'b0;
        adc_output_valid <= 1'b1;
      end
    end
  end

  assign status = {24'h00_0000, 1'b0, ref_ok, adc_busy_q, adc_output_valid,
    locked_q, 1'b0, mode};
  wire unused_ok = serial_bit_clock_i ^ ctrl_q[ctrl_dac_power] ^ ^hsize ^ ^hwdata[31:12];
endmodule // clk_mode_ctrl

// [logic/clk_mode_pkg.sv]
// Functional notes
// - dmic clock is 64 times frame rate
// - adc valid after 1059/267/2115 frames by field
// - valid delay counts frame clock rising edges
// - powerdown pin low holds device in reset
// - mode from pll power and master select
// - master clock output may glitch during setup
// - external master mode keeps master clock low
// - masters drive frame/bit clocks, slaves receive them
// - vcm plus master outputs clocks without adc/dac
// - master select one master, zero slave default
// - slave after reset until master select written
// - frame/bit pins undriven until master select
// - pll power enables generated working clock
// - only listed pll reference codes supported
// - pll locks within 2 ms or 10 ms
// - bit clock 32fs or 64fs by rate bit
// - master clock output 256/128/64/32fs by divider
// - unlocked pll master: frame low, bit high
package clk_mode_pkg;
  typedef enum logic [1:0] {
    mode_ext_slave = 2'b00,
    mode_ext_master = 2'b01,
    mode_pll_slave = 2'b10,
    mode_pll_master = 2'b11
  } clk_mode_e;

  localparam logic [31:0] ctrl_off = 32'h0000_0000;
  localparam logic [31:0] cfg_off = 32'h0000_0004;
  localparam logic [31:0] status_off = 32'h0000_0008;

  localparam int ctrl_pll_power = 0;
  localparam int ctrl_master_sel = 1;
  localparam int ctrl_mclk_out_en = 2;
  localparam int ctrl_vcm_power = 3;
  localparam int ctrl_left_adc = 4;
  localparam int ctrl_right_adc = 5;
  localparam int ctrl_dac_power = 6;
  localparam int ctrl_bit_rate = 7;
  localparam int cfg_ref_lsb = 0;
  localparam int cfg_rate_lsb = 4;
  localparam int cfg_div_lsb = 8;
  localparam int cfg_adc_init_lsb = 10;

  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [31:0] cfg_reset = 32'h0000_0000;

  localparam logic [3:0] ref_bit32 = 4'h2;
  localparam logic [3:0] ref_bit64 = 4'h3;
  localparam logic [3:0] ref_m11 = 4'h4;
  localparam logic [3:0] ref_m12 = 4'h6;
  localparam logic [3:0] ref_m24 = 4'h7;
  localparam logic [3:0] ref_m13 = 4'hc;
  localparam logic [3:0] ref_m27 = 4'hd;

  localparam logic [11:0] adc_wait_00 = 12'd1059;
  localparam logic [11:0] adc_wait_01 = 12'd267;
  localparam logic [11:0] adc_wait_1x = 12'd2115;

  localparam int clk_mhz = 200;
  localparam int lock_serial_bit_clock_ms = 2;
  localparam int lock_master_clock_input_ms = 10;
  localparam int lock_serial_bit_clock_cycles = lock_serial_bit_clock_ms * clk_mhz * 1000;
  localparam int lock_master_clock_input_cycles = lock_master_clock_input_ms * clk_mhz * 1000;

  localparam int frame_div_default = 4096;
endpackage

// [tb/clk_mode_ctrl_props.sv]
`timescale 1ns/1ps
module clk_mode_ctrl_props #(
  parameter int frame_div = 1024
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic powerdown_pin_n,
  input wire logic frame_clock_o,
  input wire logic frame_clock_oe,
  input wire logic serial_bit_clock_o,
  input wire logic serial_bit_clock_oe,
  input wire logic master_clock_output,
  input wire logic dmic_clock_output,
  input wire logic adc_output_valid,
  input wire logic pll_locked
);
  default clocking @(posedge hclk); endclocking
  // the pin is a second reset; its own two checks opt out below
  default disable iff (!hresetn || !powerdown_pin_n);
  //////////////////////////////////////////////////////////////////
  property p_pdn_quiet;
    disable iff (!hresetn)
    !powerdown_pin_n [*4] |-> !frame_clock_oe && !master_clock_output && !pll_locked
      && !adc_output_valid;
  endproperty
  a_pdn_quiet:
    assert property (p_pdn_quiet) else $error("outputs active in power-down");
  property p_slave_after_pdn;
    disable iff (!hresetn)
    $rose(powerdown_pin_n) |-> !frame_clock_oe [*3];
  endproperty
  a_slave_after_pdn:
    assert property (p_slave_after_pdn) else $error("driving clocks after power-down");
  property p_mclk_needs_lock;
    $rose(master_clock_output) |-> pll_locked;
  endproperty
  a_mclk_needs_lock:
    assert property (p_mclk_needs_lock) else $error("master clock without lock");
  property p_lock_mclk_low;
    $rose(pll_locked) |-> !$past(master_clock_output);
  endproperty
  a_lock_mclk_low:
    assert property (p_lock_mclk_low) else $error("master clock ran before lock");
  property p_oe_pair;
    frame_clock_oe |-> serial_bit_clock_oe;
  endproperty
  a_oe_pair:
    assert property (p_oe_pair) else $error("frame driven without bit clock");
  property p_frame_duty;
    $rose(frame_clock_o) |=> (frame_clock_o || !frame_clock_oe) [*8];
  endproperty
  a_frame_duty:
    assert property (p_frame_duty) else $error("frame clock high too short");
  property p_bit_duty;
    $rose(serial_bit_clock_o) |=> (serial_bit_clock_o || !serial_bit_clock_oe) [*7];
  endproperty
  a_bit_duty:
    assert property (p_bit_duty) else $error("bit clock high too short");
  property p_dmic_duty;
    $rose(dmic_clock_output) |=> dmic_clock_output [*7] ##1 !dmic_clock_output;
  endproperty
  a_dmic_duty:
    assert property (p_dmic_duty) else $error("dmic clock not half duty");
endmodule // clk_mode_ctrl_props

// [tb/host_clk_model.sv]
`timescale 1ns/1ps
module host_clk_model (
  input wire logic run,
  output logic frame,
  output logic bit_clk
);
  // 80 ns frame, 32 bit clocks; bit falls on frame edges
  always
  begin
    frame = 1'b0;
    bit_clk = 1'b0;
    wait (run);
    for (int i = 0; i < 64; i++)
    begin
      frame = i[5];
      bit_clk = i[0];
      #1.25;
    end
  end
endmodule // host_clk_model

// [tb/tb_codec_clock_mode_control.sv]
`timescale 1ns/1ps
module tb_codec_clock_mode_control;
  import clk_mode_pkg::*;
  logic hclk = 0, hresetn = 0, powerdown_pin_n = 1, hsel = 0, hwrite = 0, run = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0;
  logic hreadyout, hresp, frame_clock_i, frame_clock_o, frame_clock_oe, host_frame;
  logic serial_bit_clock_i, serial_bit_clock_o, serial_bit_clock_oe, host_bit;
  logic master_clock_output, dmic_clock_output, adc_output_valid, pll_locked;
  int mismatches = 0, compares = 0, n;
  logic [31:0] row_ctrl [4] = '{32'h0000_0002, 32'h0000_000a, 32'h0000_0049, 32'h0000_0030};
  logic [1:0] row_mode [4] = '{2'b01, 2'b01, 2'b10, 2'b00};
  logic row_oe [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  int adc_frames [3] = '{1059, 267, 2115};
  always #2.5 hclk = ~hclk;
  // released lines carry the host clocks while run is high, else sit on the pull-down
  assign frame_clock_i = frame_clock_oe ? frame_clock_o : (run ? host_frame : 1'b0);
  assign serial_bit_clock_i = serial_bit_clock_oe ? serial_bit_clock_o : (run ? host_bit : 1'b0);
  clk_mode_ctrl #(.lock_serial_bit_clock_cyc(50), .lock_master_clock_input_cyc(100), .frame_div(1024)) clk_mode_ctrl_i (
    .hclk, .hresetn, .powerdown_pin_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .frame_clock_i, .frame_clock_o,
    .frame_clock_oe, .serial_bit_clock_i, .serial_bit_clock_o, .serial_bit_clock_oe,
    .master_clock_output, .dmic_clock_output, .adc_output_valid, .pll_locked);
  host_clk_model host_clk_model_i (.run, .frame(host_frame), .bit_clk(host_bit));
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 20);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 20);
    rd = hrdata;
    hsel <= 1'b0;
    if (k >= 20)
    begin
      chk(0, 1, "bus hang");
      wrap_up();
    end
  endtask
  // rising edges of one output over one 1024-cycle frame
  task automatic edges(input int sel, output int e);
    logic [3:0] v;
    logic p;
    e = 0;
    v = {dmic_clock_output, master_clock_output, serial_bit_clock_o, frame_clock_o};
    p = v[sel];
    repeat (1024)
    begin
      @(posedge hclk);
      v = {dmic_clock_output, master_clock_output, serial_bit_clock_o, frame_clock_o};
      if (v[sel] && !p)
        e++;
      p = v[sel];
    end
  endtask
  //////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(0, ctrl_off, 0);
    chk(rd, ctrl_reset, "ctrl reset");
    xfer(0, cfg_off, 0);
    chk(rd, cfg_reset, "cfg reset");
    xfer(1, 32'h0000_000c, 32'h0000_ffff);
    xfer(0, 32'h0000_000c, 0);
    chk(rd, 0, "unmapped");
    chk(32'(frame_clock_oe), 0, "oe at reset");
    for (int i = 0; i < 4; i++)
    begin
      xfer(1, ctrl_off, row_ctrl[i]);
      repeat (8) @(posedge hclk);
      xfer(0, status_off, 0);
      chk(32'(rd[1:0]), 32'(row_mode[i]), "mode");
      chk(32'(frame_clock_oe), 32'(row_oe[i]), "oe");
    end
    $display("mode rows done");
    xfer(1, ctrl_off, 32'h0000_008e);
    repeat (40) @(posedge hclk);
    edges(0, n);
    chk(n, 1, "frame");
    edges(1, n);
    chk(n, 64, "bit 64fs");
    edges(2, n);
    chk(n, 0, "mclk ext");
    edges(3, n);
    chk(n, 64, "dmic");
    xfer(1, ctrl_off, 0);
    xfer(1, ctrl_off, 32'h0000_000a);
    repeat (40) @(posedge hclk);
    edges(1, n);
    chk(n, 32, "bit 32fs");
    $display("ext master done");
    xfer(1, ctrl_off, 0);
    xfer(1, cfg_off, {22'h0, 2'b11, 4'h0, ref_m12});
    xfer(1, ctrl_off, 32'h0000_000f);
    repeat (3) @(posedge hclk);
    chk(32'({frame_clock_o, serial_bit_clock_o}), 1, "unlocked levels");
    n = 0;
    while (pll_locked !== 1'b1 && n < 300)
    begin
      @(posedge hclk);
      n++;
    end
    chk(32'(n <= 110), 1, "lock time");
    repeat (40) @(posedge hclk);
    edges(2, n);
    chk(n, 32, "mclk 32fs");
    xfer(1, cfg_off, {26'h0, 2'b00, ref_m12});
    repeat (40) @(posedge hclk);
    edges(2, n);
    chk(n, 256, "mclk 256fs");
    xfer(1, ctrl_off, 0);
    xfer(1, cfg_off, 32'h0000_0005);
    xfer(1, ctrl_off, 32'h0000_0001);
    repeat (150) @(posedge hclk);
    xfer(0, status_off, 0);
    chk(32'({rd[6], rd[3]}), 0, "bad ref");
    $display("pll done");
    xfer(1, ctrl_off, 0);
    run <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      xfer(1, cfg_off, 32'(i) << cfg_adc_init_lsb);
      @(posedge host_frame);
      xfer(1, ctrl_off, i == 1 ? 32'h0000_0020 : 32'h0000_0010);
      n = 0;
      while (adc_output_valid !== 1'b1 && n < 3000)
      begin
        @(posedge host_frame);
        n++;
        repeat (8) @(posedge hclk);
      end
      chk(n, adc_frames[i], "adc delay");
      xfer(1, ctrl_off, 0);
    end
    $display("adc done");
    run <= 1'b0;
    xfer(1, ctrl_off, 32'h0000_000a);
    repeat (20) @(posedge hclk);
    powerdown_pin_n <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(32'({frame_clock_oe, master_clock_output}), 0, "pdn outputs");
    powerdown_pin_n <= 1'b1;
    repeat (4) @(posedge hclk);
    xfer(0, ctrl_off, 0);
    chk(rd, 0, "ctrl after pdn");
    chk(32'(frame_clock_oe), 0, "slave after pdn");
    $display("power-down done");
    wrap_up();
  end
endmodule // tb_codec_clock_mode_control
bind clk_mode_ctrl clk_mode_ctrl_props #(.frame_div(frame_div)) clk_mode_ctrl_props_i (
  .hclk, .hresetn, .powerdown_pin_n, .frame_clock_o, .frame_clock_oe, .serial_bit_clock_o,
  .serial_bit_clock_oe, .master_clock_output, .dmic_clock_output, .adc_output_valid,
  .pll_locked);
